// File: src/dbgp_defines.svh
// constants for the debug serial and trace port: status codes, idle levels, counts
// assumes inclusion by bare name from the package and the design modules
`ifndef DBGP_DEFINES_SVH
`define DBGP_DEFINES_SVH

// status nibble shown while the core is stopped
`define DBGP_HALT_STATUS 4'hF
// level of the serial output before the first shift
`define DBGP_SO_IDLE 1'b0
// default serial packet length in bits
`define DBGP_PKT_BITS 17
// nibbles in one captured 32-bit value
`define DBGP_CAP_NIBS 8
// reset level of a synchronised input
`define DBGP_SYNC_RST 1'b0

`endif

// File: src/dbgp_pkg.sv
// types for the debug serial and trace port
// assumes the defines header sits in the include path
`default_nettype none
`include "dbgp_defines.svh"

package dbgp_pkg;

  // run control of the core as seen by the debug port
  typedef enum logic [1:0] {
    HS_RUN,
    HS_PEND,
    HS_HALTED
  } dbgp_halt_e;

  // source of the debug data nibbles
  typedef enum logic {
    DD_MANUAL_BREAK_REQ_N,
    DD_STREAM
  } dbgp_dd_e;

endpackage : dbgp_pkg

`default_nettype wire

// File: src/dbgp_sync.sv
// three-flop synchroniser for one pin input
// assumes the pin is asynchronous to i_sys_clk; a new level is taken once
// the second and third flops agree
`timescale 1ns/1ns
`default_nettype none
`include "dbgp_defines.svh"

module dbgp_sync #(
  parameter logic RST_VAL = `DBGP_SYNC_RST
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_pin,
  output logic o_level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;
  wire agree = (s2_reg == s3_reg);

  // ------------------------------------------------------------
  // capture chain
  // ------------------------------------------------------------
  // first flop feeds only the second, so metastability stays contained
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      lvl_reg <= RST_VAL;
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        lvl_reg <= s3_reg;
      end
    end
  end

  assign o_level = lvl_reg;

  sync_agree_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (lvl_reg != $past(lvl_reg)) |-> ($past(s2_reg) == $past(s3_reg))
  ) else $error("synchronised level changed without two equal samples");

endmodule : dbgp_sync

`default_nettype wire

// File: src/dbgp_port.sv
// debug serial command port, manual halt and trace outputs of the core
// assumes the host keeps its serial clock slow against i_sys_clk and captures
// the trace nibbles on the rising edge of o_status_clk_out
`timescale 1ns/1ns
`default_nettype none
`include "dbgp_defines.svh"

// Notes on behaviour
// - serial clock valid after two equal samples
// - serial rise samples input, advances output
// - serial output driven only from register
// - break request halts after current instruction
// - halted core shows status 0xF
// - status clock mid-window of trace outputs
// - status follows pipeline every cycle unless halted
// - debug data refreshed every cycle
// - breakpoint status default, captures when enabled
// - write-debug-data operand shown on data bus
// - all signals one-way, rising-edge related
module dbgp_port #(
  parameter int PKT_W = `DBGP_PKT_BITS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_dbg_serial_clk,
  input wire logic i_dbg_serial_in,
  input wire logic i_manual_break_req_n,
  input wire logic i_instr_done,
  input wire logic i_resume,
  input wire logic [3:0] i_pipe_status,
  input wire logic [3:0] i_manual_break_req_n_status,
  input wire logic i_capture_en,
  input wire logic i_capture_valid,
  input wire logic [31:0] i_capture_data,
  input wire logic i_write_debug_data_instr_exec,
  input wire logic [31:0] i_write_debug_data_instr_operand,
  input wire logic i_tx_load,
  input wire logic [PKT_W-1:0] i_tx_word,
  output logic [PKT_W-1:0] o_rx_word,
  output logic o_rx_valid,
  output logic o_dbg_serial_out,
  output logic o_halted,
  output logic o_status_clk_out,
  output logic [3:0] o_proc_status_bus,
  output logic [3:0] o_dbg_data_bus
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic sclk_lvl;
  logic din_lvl;
  logic brk_n_lvl;

  dbgp_sync #(.RST_VAL(1'b0)) u_sync_clk (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_dbg_serial_clk),
    .o_level(sclk_lvl)
  );

  dbgp_sync #(.RST_VAL(1'b0)) u_sync_din (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_dbg_serial_in),
    .o_level(din_lvl)
  );

  // break request idles high, so its chain resets high to avoid a false halt
  dbgp_sync #(.RST_VAL(1'b1)) u_sync_brk (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_manual_break_req_n),
    .o_level(brk_n_lvl)
  );

  // ------------------------------------------------------------
  // serial shifter
  // ------------------------------------------------------------
  localparam int CNT_W = $clog2(PKT_W + 1);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(PKT_W - 1);

  logic sclk_prev_reg;
  logic [PKT_W-1:0] rx_shift_reg;
  logic [PKT_W-1:0] rx_word_reg;
  logic rx_valid_reg;
  logic [CNT_W-1:0] bit_cnt_reg;
  logic [PKT_W-1:0] tx_shift_reg;
  logic so_reg;

  // edge found on the validated level, never on the raw pin
  wire ser_rise = sclk_lvl & ~sclk_prev_reg;
  wire pkt_end = ser_rise & (bit_cnt_reg == LAST_BIT);
  wire [PKT_W-1:0] rx_shift_next = {rx_shift_reg[PKT_W-2:0], din_lvl};
  wire [CNT_W-1:0] bit_cnt_next = pkt_end ? '0 : bit_cnt_reg + CNT_W'(1);

  // receive side: one bit per validated rising edge
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_prev_reg <= 1'b0;
      rx_shift_reg <= '0;
      rx_word_reg <= '0;
      rx_valid_reg <= 1'b0;
      bit_cnt_reg <= '0;
    end else begin
      sclk_prev_reg <= sclk_lvl;
      rx_valid_reg <= pkt_end;
      if (ser_rise) begin
        rx_shift_reg <= rx_shift_next;
        bit_cnt_reg <= bit_cnt_next;
      end
      if (pkt_end) begin
        rx_word_reg <= rx_shift_next;
      end
    end
  end

  // transmit side: a load is taken at once unless a serial rise comes in the same cycle, the msb goes first
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_shift_reg <= '0;
      so_reg <= `DBGP_SO_IDLE;
    end else if (ser_rise) begin
      so_reg <= tx_shift_reg[PKT_W-1];
      tx_shift_reg <= {tx_shift_reg[PKT_W-2:0], 1'b0};
    end else if (i_tx_load) begin
      tx_shift_reg <= i_tx_word;
    end
  end

  assign o_rx_word = rx_word_reg;
  assign o_rx_valid = rx_valid_reg;
  assign o_dbg_serial_out = so_reg;

  // ------------------------------------------------------------
  // manual halt
  // ------------------------------------------------------------
  dbgp_pkg::dbgp_halt_e hs_reg;
  dbgp_pkg::dbgp_halt_e hs_next;

  // request is a level; it is remembered until the running instruction ends
  always_comb begin
    hs_next = hs_reg;
    case (hs_reg)
      dbgp_pkg::HS_RUN: begin
        if (!brk_n_lvl) begin
          hs_next = i_instr_done ? dbgp_pkg::HS_HALTED : dbgp_pkg::HS_PEND;
        end
      end
      dbgp_pkg::HS_PEND: begin
        if (i_instr_done) begin
          hs_next = dbgp_pkg::HS_HALTED;
        end
      end
      dbgp_pkg::HS_HALTED: begin
        if (i_resume && brk_n_lvl) begin
          hs_next = dbgp_pkg::HS_RUN;
        end
      end
      default: hs_next = dbgp_pkg::HS_RUN;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hs_reg <= dbgp_pkg::HS_RUN;
    end else begin
      hs_reg <= hs_next;
    end
  end

  assign o_halted = (hs_reg == dbgp_pkg::HS_HALTED);

  // ------------------------------------------------------------
  // trace outputs
  // ------------------------------------------------------------
  localparam logic [3:0] NIB_LAST = 4'(`DBGP_CAP_NIBS - 1);

  logic [3:0] pst_reg;
  logic [3:0] dd_reg;
  logic [31:0] cap_reg;
  logic [3:0] nib_cnt_reg;
  dbgp_pkg::dbgp_dd_e dd_src_reg;

  // write-debug-data always captures; bus capture only when enabled
  wire cap_load = i_write_debug_data_instr_exec | (i_capture_en & i_capture_valid);
  wire [31:0] cap_in = i_write_debug_data_instr_exec ? i_write_debug_data_instr_operand : i_capture_data;
  wire stream_end = (dd_src_reg == dbgp_pkg::DD_STREAM) & (nib_cnt_reg == NIB_LAST);
  wire [3:0] pst_next = o_halted ? `DBGP_HALT_STATUS : i_pipe_status;
  wire [3:0] dd_next = (dd_src_reg == dbgp_pkg::DD_STREAM) ? cap_reg[3:0] : i_manual_break_req_n_status;

  // both nibble buses are refreshed on every core clock edge
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pst_reg <= '0;
      dd_reg <= '0;
    end else begin
      pst_reg <= pst_next;
      dd_reg <= dd_next;
    end
  end

  // capture buffer, shown low nibble first; a new capture restarts it
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cap_reg <= '0;
      nib_cnt_reg <= '0;
      dd_src_reg <= dbgp_pkg::DD_MANUAL_BREAK_REQ_N;
    end else if (cap_load) begin
      cap_reg <= cap_in;
      nib_cnt_reg <= '0;
      dd_src_reg <= dbgp_pkg::DD_STREAM;
    end else if (dd_src_reg == dbgp_pkg::DD_STREAM) begin
      cap_reg <= {4'h0, cap_reg[31:4]};
      nib_cnt_reg <= nib_cnt_reg + 4'h1;
      if (stream_end) begin
        dd_src_reg <= dbgp_pkg::DD_MANUAL_BREAK_REQ_N;
      end
    end
  end

  assign o_proc_status_bus = pst_reg;
  assign o_dbg_data_bus = dd_reg;
  // inverted core clock: its rise sits half a period after the data edge,
  // mid-window; trade-off is a clock path out through logic, no flop
  assign o_status_clk_out = ~i_sys_clk;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  halt_status_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (hs_reg == dbgp_pkg::HS_HALTED) |=> (o_proc_status_bus == 4'hF)
  ) else $error("halted core not showing status F");

  pipe_follow_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (hs_reg != dbgp_pkg::HS_HALTED) |=> (o_proc_status_bus == $past(i_pipe_status))
  ) else $error("status bus not following pipeline");

  halt_wait_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (hs_reg == dbgp_pkg::HS_PEND && !i_instr_done) |=> (hs_reg == dbgp_pkg::HS_PEND)
  ) else $error("halt taken before instruction finished");

  halt_entry_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (!brk_n_lvl && hs_reg != dbgp_pkg::HS_HALTED && i_instr_done) |=> o_halted ##1 (o_proc_status_bus == 4'hF)
  ) else $error("halt not entered at instruction end");

  so_hold_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    !ser_rise |=> (o_dbg_serial_out == $past(o_dbg_serial_out))
  ) else $error("serial output moved without serial clock edge");

  rx_sample_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    ser_rise |=> (rx_shift_reg[0] == $past(din_lvl)) && (o_dbg_serial_out == $past(tx_shift_reg[PKT_W-1]))
  ) else $error("serial edge did not sample and shift");

  dd_default_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (dd_src_reg == dbgp_pkg::DD_MANUAL_BREAK_REQ_N) |=> (o_dbg_data_bus == $past(i_manual_break_req_n_status))
  ) else $error("debug data not showing breakpoint status");

  wdd_show_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    i_write_debug_data_instr_exec |-> ##2 (o_dbg_data_bus == $past(i_write_debug_data_instr_operand[3:0], 2))
  ) else $error("write-debug-data operand not shown");

endmodule : dbgp_port

`default_nettype wire

// File: tb/dbgp_host.sv
// host probe model: drives serial clock, serial data and manual break
// assumes the port samples all pins on its own core clock
`timescale 1ns/1ns
`default_nettype none
module dbgp_host #(
  parameter int PKT_W = 17
) (
  input wire logic i_dbg_serial_out,
  output logic o_dbg_serial_clk,
  output logic o_dbg_serial_in,
  output logic o_manual_break_req_n
);
  // serial clock idles low; between packets only the glitch task pulses it
  initial begin
    o_dbg_serial_clk = 1'b0;
    o_dbg_serial_in = 1'b0;
    o_manual_break_req_n = 1'b1;
  end
  // one packet msb first; 390 ns bit time stays below a fifth of the core rate
  task automatic xfer(input logic [PKT_W-1:0] tx, output logic [PKT_W-1:0] rx);
    for (int i = PKT_W - 1; i >= 0; i--) begin
      o_dbg_serial_in = tx[i];
      #10 o_dbg_serial_clk = 1'b1;
      #200 o_dbg_serial_clk = 1'b0;
      #180 rx[i] = i_dbg_serial_out; // late in the bit, output long settled
    end
    #10 o_dbg_serial_in = ~tx[0]; // released line shows the inverse, never a stale bit
  endtask : xfer
  // pulse shorter than one core period: no two edges can see it
  task automatic glitch;
    #10 o_dbg_serial_clk = 1'b1;
    #20 o_dbg_serial_clk = 1'b0;
    #400;
  endtask : glitch
  task automatic brk(input logic lvl);
    o_manual_break_req_n = lvl;
  endtask : brk
endmodule : dbgp_host
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the debug serial and trace port
// assumes the host model file and the design sources are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "dbgp_defines.svh"
module tb_top;
  localparam int PKT_W = 17;
  logic i_sys_clk, i_rst_b, i_instr_done, i_resume, i_capture_en, i_capture_valid, i_write_debug_data_instr_exec, i_tx_load;
  logic [3:0] i_pipe_status, i_manual_break_req_n_status, o_proc_status_bus, o_dbg_data_bus;
  logic [31:0] i_capture_data, i_write_debug_data_instr_operand;
  logic [PKT_W-1:0] i_tx_word, o_rx_word;
  logic o_rx_valid, o_dbg_serial_out, o_halted, o_status_clk_out, ser_clk, ser_in, brk_n;
  int n_mismatch, checks, seed;

  dbgp_port #(.PKT_W(PKT_W)) uut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_dbg_serial_clk(ser_clk),
    .i_dbg_serial_in(ser_in), .i_manual_break_req_n(brk_n), .i_instr_done(i_instr_done), .i_resume(i_resume),
    .i_pipe_status(i_pipe_status), .i_manual_break_req_n_status(i_manual_break_req_n_status), .i_capture_en(i_capture_en),
    .i_capture_valid(i_capture_valid), .i_capture_data(i_capture_data), .i_write_debug_data_instr_exec(i_write_debug_data_instr_exec),
    .i_write_debug_data_instr_operand(i_write_debug_data_instr_operand), .i_tx_load(i_tx_load), .i_tx_word(i_tx_word), .o_rx_word(o_rx_word),
    .o_rx_valid(o_rx_valid), .o_dbg_serial_out(o_dbg_serial_out), .o_halted(o_halted),
    .o_status_clk_out(o_status_clk_out), .o_proc_status_bus(o_proc_status_bus), .o_dbg_data_bus(o_dbg_data_bus));
  dbgp_host #(.PKT_W(PKT_W)) host (.i_dbg_serial_out(o_dbg_serial_out), .o_dbg_serial_clk(ser_clk),
    .o_dbg_serial_in(ser_in), .o_manual_break_req_n(brk_n));

  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  // --------------------------------------------------
  // compare and expectation helpers
  // --------------------------------------------------
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic chk_nib(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_nib
  task automatic chk_word(input string what, input logic [PKT_W-1:0] exp, input logic [PKT_W-1:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  function automatic logic [3:0] exp_status(input logic halt, input logic [3:0] p);
    return halt ? `DBGP_HALT_STATUS : p;
  endfunction : exp_status
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // random pipeline and breakpoint nibbles, each checked one cycle later
  task automatic rand_trace(input int n, input logic halt);
    logic [3:0] p, b;
    for (int k = 0; k < n; k++) begin
      @(negedge i_sys_clk);
      if (k > 0) chk_nib("status", exp_status(halt, p), o_proc_status_bus);
      if (k > 0) chk_nib("data", b, o_dbg_data_bus);
      p = 4'($random(seed));
      b = 4'($random(seed));
      i_pipe_status = p;
      i_manual_break_req_n_status = b;
    end
  endtask : rand_trace
  // kind 0 write-debug-data, 1 enabled capture, 2 capture disabled, 3 both at once
  task automatic cap(input int kind);
    logic [31:0] op;
    op = $random(seed);
    @(negedge i_sys_clk);
    i_write_debug_data_instr_exec = (kind == 0 || kind == 3);
    i_write_debug_data_instr_operand = op;
    i_capture_en = (kind == 1 || kind == 3);
    i_capture_valid = (kind != 0);
    i_capture_data = (kind == 3) ? ~op : op;
    @(negedge i_sys_clk);
    i_write_debug_data_instr_exec = 1'b0;
    i_capture_valid = 1'b0;
    // capture lands at the edge inside the pulse, low nibble shows one edge later
    repeat (1) @(negedge i_sys_clk);
    for (int k = 0; k < 9; k++) begin
      chk_nib("nibble", (kind == 2 || k == 8) ? i_manual_break_req_n_status : op[4*k +: 4], o_dbg_data_bus);
      @(negedge i_sys_clk);
    end
    i_capture_en = 1'b0;
  endtask : cap
  // one packet both ways; the valid pulse is watched while the host shifts
  task automatic pkt(input logic [PKT_W-1:0] to_host, input logic [PKT_W-1:0] to_dev);
    logic [PKT_W-1:0] got, word;
    logic seen;
    seen = 1'b0;
    @(negedge i_sys_clk);
    i_tx_load = 1'b1;
    i_tx_word = to_host;
    @(negedge i_sys_clk);
    i_tx_load = 1'b0;
    fork
      host.xfer(to_dev, got);
      for (int c = 0; c < PKT_W * 8 + 40 && !seen; c++) begin
        @(negedge i_sys_clk);
        if (o_rx_valid === 1'b1) seen = 1'b1;
        word = o_rx_word;
      end
    join
    chk_bit("rx valid", 1'b1, seen);
    chk_word("rx word", to_dev, word);
    chk_word("serial out", to_host, got);
  endtask : pkt
  // --------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------
  initial begin
    seed = 28498;
    {i_rst_b, i_instr_done, i_resume, i_capture_en, i_capture_valid, i_write_debug_data_instr_exec, i_tx_load} = '0;
    {i_pipe_status, i_manual_break_req_n_status, i_capture_data, i_write_debug_data_instr_operand, i_tx_word} = '0;
    // nonzero breakpoint nibble, so the first refresh differs from the reset value
    i_manual_break_req_n_status = 4'hA;
    repeat (12) @(negedge i_sys_clk);
    chk_bit("serial idle", `DBGP_SO_IDLE, o_dbg_serial_out);
    i_rst_b = 1'b1;
    @(negedge i_sys_clk);
    chk_nib("data after reset", i_manual_break_req_n_status, o_dbg_data_bus);
    chk_bit("status clk", 1'b1, o_status_clk_out);
    rand_trace(40, 1'b0);
    $display("test trace done");
    for (int k = 0; k < 4; k++) cap(k);
    $display("test capture done");
    pkt(PKT_W'($random(seed)), PKT_W'($random(seed)));
    pkt(PKT_W'($random(seed)), PKT_W'($random(seed)));
    host.glitch();
    pkt('1, '0);
    $display("test serial done");
    host.brk(1'b0);
    repeat (8) @(negedge i_sys_clk);
    chk_bit("halt before done", 1'b0, o_halted);
    i_instr_done = 1'b1;
    @(negedge i_sys_clk);
    i_instr_done = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    chk_bit("halt after done", 1'b1, o_halted);
    rand_trace(6, 1'b1);
    i_resume = 1'b1;
    @(negedge i_sys_clk);
    i_resume = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    chk_bit("resume refused", 1'b1, o_halted);
    host.brk(1'b1);
    repeat (8) @(negedge i_sys_clk);
    i_resume = 1'b1;
    @(negedge i_sys_clk);
    i_resume = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    chk_bit("resumed", 1'b0, o_halted);
    rand_trace(6, 1'b0);
    $display("test halt done");
    complete_run();
  end
  // a hang is cut well past the roughly 30 us the tests need
  initial begin
    #500000;
    n_mismatch++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
